// File: pwf_framer.sv
// Pseudo-wire header framer: builds transmit headers, checks received headers.
// Assumes an AXI4-Lite master, a header sink with ready, and a word-wide
// receive stream whose header words arrive first, one 32-bit word per beat.
module pwf_framer #(
  parameter int     TS_TICK_CYC   = pwf_pkg::TS_TICK_CYC,
  parameter longint XR_PERIOD_CYC = pwf_pkg::XR_PERIOD_CYC
) (
  input  wire logic                core_clk,                // 200 MHz
  input  wire logic                rst,                     // Sync, active high
  input  wire logic [7:0]          s_axi_awaddr,            // Write address
  input  wire logic                s_axi_awvalid,           // Write address valid
  output logic                     s_axi_awready,           // Write address ready
  input  wire logic [31:0]         s_axi_wdata,             // Write data
  input  wire logic [3:0]          s_axi_wstrb,             // Byte enables
  input  wire logic                s_axi_wvalid,            // Write data valid
  output logic                     s_axi_wready,            // Write data ready
  output logic [1:0]               s_axi_bresp,             // Write response
  output logic                     s_axi_bvalid,            // Write response valid
  input  wire logic                s_axi_bready,            // Write response ready
  input  wire logic [7:0]          s_axi_araddr,            // Read address
  input  wire logic                s_axi_arvalid,           // Read address valid
  output logic                     s_axi_arready,           // Read address ready
  output logic [31:0]              s_axi_rdata,             // Read data
  output logic [1:0]               s_axi_rresp,             // Read response
  output logic                     s_axi_rvalid,            // Read data valid
  input  wire logic                s_axi_rready,            // Read data ready
  input  wire logic                signal_loss_defect,      // TDM loss of signal
  input  wire logic                frame_alignment_loss,    // TDM frame loss
  input  wire logic                alarm_indication_defect, // TDM alarm indication
  input  wire logic                packet_loss_state,       // Loss of packets
  input  wire logic                tx_req_valid,            // Header request
  input  pwf_pkg::pwf_txreq_t      tx_req,                  // Request fields
  output logic                     tx_req_ready,            // Request taken
  output logic [31:0]              hdr_data,                // Header word
  output logic                     hdr_valid,               // Header word valid
  output logic                     hdr_last,                // Last header word
  input  wire logic                hdr_ready,               // Sink ready
  input  wire logic [31:0]         rx_data,                 // Received word
  input  wire logic                rx_valid,                // Received word valid
  input  wire logic                rx_last,                 // Last word of datagram
  output logic                     rx_ready,                // Always ready
  output logic                     rx_accept,               // Datagram accepted
  output logic                     rx_drop,                 // Datagram dropped
  output pwf_pkg::pwf_rxinfo_t     rx_info,                 // Accepted header
  output logic [31:0]              rtp_timestamp,           // Timestamp counter
  output logic                     xr4_due,                 // Send block 4 report
  output logic                     xr5_due                  // Send block 5 report
);

  typedef enum logic {TX_IDLE, TX_SEND} pwf_tx_state_t;

  function automatic logic [31:0] pwf_wmask(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [pwf_pkg::CTRL_W-1:0] ctrl_q;
  logic [31:0]                ports_q;
  logic [31:0]                src_ip_q;
  logic [31:0]                dst_ip_q;
  logic [22:0]                pt_q;
  logic [31:0]                ssrc_q;
  logic                       cfg_err_q;
  logic [15:0]                drops_q;
  logic                       l_q;
  logic                       r_q;
  logic                       aw_hold_q;
  logic                       w_hold_q;
  logic [7:0]                 aw_addr_q;
  logic [31:0]                w_data_q;
  logic [3:0]                 w_strb_q;
  logic                       wr_fire;
  logic [31:0]                wr_val;
  logic                       wr_bad;
  logic                       wr_unmap;
  logic [31:0]                rd_val;
  logic                       rd_unmap;

  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

  always_comb begin
    wr_val   = 32'h00000000;
    wr_bad   = 1'b0;
    wr_unmap = 1'b0;
    unique case (aw_addr_q)
      pwf_pkg::REG_CTRL: begin
        wr_val = pwf_wmask({25'h0000000, ctrl_q}, w_data_q, w_strb_q);
        wr_bad = wr_val[pwf_pkg::CTRL_IP6];
      end
      pwf_pkg::REG_PORTS: begin
        wr_val = pwf_wmask(ports_q, w_data_q, w_strb_q);
        wr_bad = (wr_val[31:16] <= pwf_pkg::PORT_WK_MAX)
               || (wr_val[15:0] < pwf_pkg::PORT_DYN);
      end
      pwf_pkg::REG_SRC_IP: wr_val = pwf_wmask(src_ip_q, w_data_q, w_strb_q);
      pwf_pkg::REG_DST_IP: wr_val = pwf_wmask(dst_ip_q, w_data_q, w_strb_q);
      pwf_pkg::REG_PT:     wr_val = pwf_wmask({9'h000, pt_q}, w_data_q, w_strb_q);
      pwf_pkg::REG_SSRC:   wr_val = pwf_wmask(ssrc_q, w_data_q, w_strb_q);
      pwf_pkg::REG_STATUS: wr_val = w_data_q;
      pwf_pkg::REG_DROPS:  wr_val = w_data_q;
      default:             wr_unmap = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pwf_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_hold_q) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_hold_q) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_bad || wr_unmap) ? pwf_pkg::RESP_SLVERR : pwf_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Refused values leave the register unchanged
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q   <= pwf_pkg::CTRL_RST;
      ports_q  <= pwf_pkg::PORTS_RST;
      src_ip_q <= 32'h00000000;
      dst_ip_q <= 32'h00000000;
      pt_q     <= pwf_pkg::PT_RST;
      ssrc_q   <= 32'h00000000;
    end else if (wr_fire && !wr_bad) begin
      unique case (aw_addr_q)
        pwf_pkg::REG_CTRL:   ctrl_q   <= wr_val[pwf_pkg::CTRL_W-1:0];
        pwf_pkg::REG_PORTS:  ports_q  <= wr_val;
        pwf_pkg::REG_SRC_IP: src_ip_q <= wr_val;
        pwf_pkg::REG_DST_IP: dst_ip_q <= wr_val;
        pwf_pkg::REG_PT:     pt_q     <= wr_val[22:0];
        pwf_pkg::REG_SSRC:   ssrc_q   <= wr_val;
        default: ;
      endcase
    end
  end

  // Sticky refusal flag, write one to clear; a new refusal wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_err_q <= 1'b0;
    end else if (wr_fire && wr_bad) begin
      cfg_err_q <= 1'b1;
    end else if (wr_fire && aw_addr_q == pwf_pkg::REG_STATUS && w_strb_q[0]
                 && w_data_q[pwf_pkg::STAT_ERR]) begin
      cfg_err_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  always_comb begin
    rd_val   = 32'h00000000;
    rd_unmap = 1'b0;
    unique case (s_axi_araddr)
      pwf_pkg::REG_CTRL:   rd_val = {25'h0000000, ctrl_q};
      pwf_pkg::REG_PORTS:  rd_val = ports_q;
      pwf_pkg::REG_SRC_IP: rd_val = src_ip_q;
      pwf_pkg::REG_DST_IP: rd_val = dst_ip_q;
      pwf_pkg::REG_PT:     rd_val = {9'h000, pt_q};
      pwf_pkg::REG_SSRC:   rd_val = ssrc_q;
      pwf_pkg::REG_STATUS: rd_val = {29'h00000000, cfg_err_q, r_q, l_q};
      pwf_pkg::REG_DROPS:  rd_val = {16'h0000, drops_q};
      default:             rd_unmap = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= pwf_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_unmap ? pwf_pkg::RESP_SLVERR : pwf_pkg::RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Failure flags

  always_ff @(posedge core_clk) begin
    if (rst) begin
      l_q <= 1'b0;
      r_q <= 1'b0;
    end else begin
      if (ctrl_q[pwf_pkg::CTRL_AWARE]) begin
        l_q <= signal_loss_defect || frame_alignment_loss
            || alarm_indication_defect;
      end else begin
        l_q <= signal_loss_defect
            || (ctrl_q[pwf_pkg::CTRL_AIS_L] && alarm_indication_defect);
      end
      r_q <= packet_loss_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timestamp and report timers

  logic [$clog2(TS_TICK_CYC)-1:0] ts_div_q;
  logic [39:0]                    xr_cnt_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ts_div_q      <= '0;
      rtp_timestamp <= 32'h00000000;
    end else if (ts_div_q == ($clog2(TS_TICK_CYC))'(TS_TICK_CYC - 1)) begin
      ts_div_q      <= '0;
      rtp_timestamp <= rtp_timestamp + 32'h00000001;
    end else begin
      ts_div_q <= ts_div_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      xr_cnt_q <= 40'h0000000000;
      xr4_due  <= 1'b0;
      xr5_due  <= 1'b0;
    end else if (xr_cnt_q == 40'(XR_PERIOD_CYC - 1)) begin
      xr_cnt_q <= 40'h0000000000;
      xr4_due  <= ctrl_q[pwf_pkg::CTRL_XR4];
      xr5_due  <= ctrl_q[pwf_pkg::CTRL_XR5];
    end else begin
      xr_cnt_q <= xr_cnt_q + 40'h0000000001;
      xr4_due  <= 1'b0;
      xr5_due  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit header builder

  pwf_tx_state_t       tx_state_q;
  pwf_pkg::pwf_txreq_t req_q;
  logic [3:0]          idx_q;
  logic [3:0]          nwords_q;
  logic [31:0]         cw_q;
  logic [31:0]         ts_q;
  logic [15:0]         ip_id_q;
  logic [15:0]         seq_data_q;
  logic [15:0]         seq_sig_q;
  logic [1:0]          m_code;
  logic [15:0]         seq_cur;
  logic [15:0]         tot_len;
  logic [19:0]         csum_acc;
  logic [15:0]         csum;
  logic [31:0]         words [0:10];

  assign seq_cur = tx_req.sig ? seq_sig_q : seq_data_q;

  always_comb begin
    if (l_q) begin
      m_code = pwf_pkg::M_NORMAL;
    end else if (tx_req.sig) begin
      m_code = pwf_pkg::M_SIG;
    end else if (tx_req.remote_alarm_indication && ctrl_q[pwf_pkg::CTRL_AWARE]) begin
      m_code = pwf_pkg::M_RAI;
    end else begin
      m_code = pwf_pkg::M_NORMAL;
    end
  end

  always_comb begin
    tot_len = pwf_pkg::IP_HDR_B + pwf_pkg::UDP_CW_B + req_q.pay_len
            + (ctrl_q[pwf_pkg::CTRL_RTP] ? pwf_pkg::RTP_B : 16'h0000);
    words[0] = {pwf_pkg::IP_VER4, pwf_pkg::IP_IHL, pwf_pkg::IP_TOS, tot_len};
    words[1] = {ip_id_q, pwf_pkg::IP_FLAGS_DF, 13'h0000};
    words[2] = {pwf_pkg::IP_TTL, pwf_pkg::IP_PROTO, 16'h0000};
    words[3] = src_ip_q;
    words[4] = dst_ip_q;
    csum_acc = 20'h00000;
    for (int i = 0; i < 5; i++) begin
      csum_acc = csum_acc + {4'h0, words[i][31:16]} + {4'h0, words[i][15:0]};
    end
    csum_acc = {4'h0, csum_acc[15:0]} + {16'h0000, csum_acc[19:16]};
    csum_acc = {4'h0, csum_acc[15:0]} + {16'h0000, csum_acc[19:16]};
    csum     = ~csum_acc[15:0];
    words[2] = {pwf_pkg::IP_TTL, pwf_pkg::IP_PROTO, csum};
    words[5] = {ports_q[15:0], ports_q[31:16]};
    words[6] = {tot_len - pwf_pkg::IP_HDR_B, 16'h0000};
    words[7] = cw_q;
    words[8] = {pwf_pkg::RTP_VER, 1'b0, 1'b0, 4'h0, 1'b0,
                req_q.sig ? pt_q[14:8] : pt_q[6:0], cw_q[15:0]};
    words[9]  = ts_q;
    words[10] = ssrc_q;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_state_q   <= TX_IDLE;
      tx_req_ready <= 1'b0;
      req_q        <= '0;
      idx_q        <= 4'h0;
      nwords_q     <= pwf_pkg::WORDS_BASE;
      cw_q         <= 32'h00000000;
      ts_q         <= 32'h00000000;
      ip_id_q      <= 16'h0000;
      seq_data_q   <= 16'h0000;
      seq_sig_q    <= 16'h0000;
      hdr_data     <= 32'h00000000;
      hdr_valid    <= 1'b0;
      hdr_last     <= 1'b0;
    end else begin
      unique case (tx_state_q)
        TX_IDLE: begin
          tx_req_ready <= ctrl_q[pwf_pkg::CTRL_EN];
          if (tx_req_valid && tx_req_ready) begin
            tx_req_ready <= 1'b0;
            req_q        <= tx_req;
            idx_q        <= 4'h0;
            nwords_q     <= ctrl_q[pwf_pkg::CTRL_RTP] ? pwf_pkg::WORDS_RTP
                                                      : pwf_pkg::WORDS_BASE;
            cw_q         <= {4'h0, l_q, r_q, m_code, 8'h00, seq_cur};
            ts_q         <= rtp_timestamp;
            tx_state_q   <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (!hdr_valid || hdr_ready) begin
            if (idx_q == nwords_q) begin
              hdr_valid  <= 1'b0;
              hdr_last   <= 1'b0;
              ip_id_q    <= ip_id_q + 16'h0001;
              tx_state_q <= TX_IDLE;
              if (req_q.sig) begin
                seq_sig_q <= seq_sig_q + 16'h0001;
              end else begin
                seq_data_q <= seq_data_q + 16'h0001;
              end
            end else begin
              hdr_data  <= words[idx_q];
              hdr_valid <= 1'b1;
              hdr_last  <= (idx_q == nwords_q - 4'h1);
              idx_q     <= idx_q + 4'h1;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive header checker

  logic [3:0]  ridx_q;
  logic        bad_q;
  logic        bad_now;
  logic        beat;
  logic [15:0] rx_src_q;
  logic [31:0] rx_cw_q;
  logic [3:0]  rx_need;

  assign beat    = rx_valid && rx_ready;
  assign rx_need = ctrl_q[pwf_pkg::CTRL_RTP] ? pwf_pkg::WORDS_RTP : pwf_pkg::WORDS_BASE;

  always_comb begin
    unique case (ridx_q)
      4'h0:    bad_now = rx_data[31:28] != pwf_pkg::IP_VER4;
      4'h2:    bad_now = rx_data[31:24] == 8'h00;
      4'h5:    bad_now = rx_data[15:0] != ports_q[15:0];
      4'h7:    bad_now = rx_data[27] && rx_data[25:24] != pwf_pkg::M_NORMAL;
      default: bad_now = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ridx_q    <= 4'h0;
      bad_q     <= 1'b0;
      rx_src_q  <= 16'h0000;
      rx_cw_q   <= 32'h00000000;
      rx_ready  <= 1'b0;
      rx_accept <= 1'b0;
      rx_drop   <= 1'b0;
      rx_info   <= '0;
      drops_q   <= 16'h0000;
    end else begin
      rx_ready  <= 1'b1;
      rx_accept <= 1'b0;
      rx_drop   <= 1'b0;
      if (beat) begin
        if (ridx_q == 4'h5) begin
          rx_src_q <= rx_data[31:16];
        end
        if (ridx_q == 4'h7) begin
          rx_cw_q <= rx_data;
        end
        if (rx_last) begin
          ridx_q <= 4'h0;
          bad_q  <= 1'b0;
          if (bad_q || bad_now || ridx_q < rx_need - 4'h1
              || !ctrl_q[pwf_pkg::CTRL_EN]) begin
            rx_drop <= 1'b1;
            drops_q <= drops_q + 16'h0001;
          end else begin
            rx_accept <= 1'b1;
            rx_info   <= {rx_cw_q[27], rx_cw_q[26], rx_cw_q[25:24],
                          rx_cw_q[15:0], rx_src_q};
          end
        end else begin
          bad_q <= bad_q || bad_now;
          if (ridx_q != 4'hF) begin
            ridx_q <= ridx_q + 4'h1;
          end
        end
      end
    end
  end

endmodule

// File: pwf_pkg.sv
// Constants, register map and carrier types of the pseudo-wire header framer.
// Assumes one 200 MHz clock and a synchronous active-high reset.
package pwf_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_PORTS  = 8'h04;
  localparam logic [7:0] REG_SRC_IP = 8'h08;
  localparam logic [7:0] REG_DST_IP = 8'h0C;
  localparam logic [7:0] REG_PT     = 8'h10;
  localparam logic [7:0] REG_SSRC   = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_DROPS  = 8'h1C;
  // Control bit positions
  localparam int CTRL_EN    = 0;
  localparam int CTRL_IP6   = 1;
  localparam int CTRL_RTP   = 2;
  localparam int CTRL_AWARE = 3;
  localparam int CTRL_AIS_L = 4;
  localparam int CTRL_XR4   = 5;
  localparam int CTRL_XR5   = 6;
  localparam int CTRL_W     = 7;
  // Status bit positions
  localparam int STAT_L   = 0;
  localparam int STAT_R   = 1;
  localparam int STAT_ERR = 2;
  // Reset values
  localparam logic [6:0]  CTRL_RST  = 7'h00;
  localparam logic [31:0] PORTS_RST = 32'hC000C000;
  localparam logic [22:0] PT_RST    = 23'h000000;
  // Header constants
  localparam logic [3:0]  IP_VER4     = 4'h4;
  localparam logic [3:0]  IP_IHL      = 4'h5;
  localparam logic [7:0]  IP_TOS      = 8'h00;
  localparam logic [2:0]  IP_FLAGS_DF = 3'h2;
  localparam logic [7:0]  IP_TTL      = 8'h40;
  localparam logic [7:0]  IP_PROTO    = 8'h11;
  localparam logic [15:0] IP_HDR_B    = 16'h0014;
  localparam logic [15:0] UDP_CW_B    = 16'h000C;
  localparam logic [15:0] RTP_B       = 16'h000C;
  localparam logic [15:0] PORT_WK_MAX = 16'h03FF;
  localparam logic [15:0] PORT_DYN    = 16'hC000;
  localparam logic [1:0]  RTP_VER     = 2'h2;
  localparam logic [1:0]  M_NORMAL    = 2'h0;
  localparam logic [1:0]  M_RAI       = 2'h2;
  localparam logic [1:0]  M_SIG       = 2'h3;
  localparam logic [3:0]  WORDS_BASE  = 4'h8;
  localparam logic [3:0]  WORDS_RTP   = 4'hB;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // Timing
  localparam longint CLK_HZ        = 200000000;
  localparam longint TS_RATE_HZ    = 8000;
  localparam int     TS_TICK_CYC   = int'(CLK_HZ / TS_RATE_HZ);
  localparam longint XR_PERIOD_MIN = 10;
  localparam longint XR_PERIOD_CYC = XR_PERIOD_MIN * 60 * CLK_HZ;

  typedef struct packed {
    logic        sig;      // Signaling-only packet
    logic        remote_alarm_indication;      // Remote alarm seen at the TDM input
    logic [15:0] pay_len;  // Payload bytes
  } pwf_txreq_t;

  typedef struct packed {
    logic        l;
    logic        r;
    logic [1:0]  m;
    logic [15:0] seq;
    logic [15:0] src_port;
  } pwf_rxinfo_t;
endpackage

// File: pwf_chk_assertions.sv
// Checker on the framer's outgoing header words.
// Assumes the framer's port names; attached by the bind at the foot.
module pwf_chk (
  input wire logic        core_clk,  // Clock
  input wire logic        rst,       // Reset
  input wire logic [31:0] hdr_data,  // Word
  input wire logic        hdr_valid, // Valid
  input wire logic        hdr_last,  // Last
  input wire logic        hdr_ready  // Ready
);
  logic [3:0]  w_q;
  logic [15:0] seq_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk) begin
    if (rst || (hdr_valid && hdr_ready && hdr_last)) w_q <= 4'h0;
    else if (hdr_valid && hdr_ready) w_q <= w_q + 4'h1;
  end
  always_ff @(posedge core_clk) begin
    if (hdr_valid && hdr_ready && w_q == 4'h7) seq_q <= hdr_data[15:0];
  end
  ////////////////////////////////////////////////////////////////
  a_hold_word: assert property (hdr_valid && !hdr_ready |=> hdr_valid && $stable(hdr_data))
    else $error("word moved");
  a_ver_four: assert property (hdr_valid && w_q == 4'h0 |-> hdr_data[31:24] == 8'h45)
    else $error("version");
  a_no_frag: assert property (hdr_valid && w_q == 4'h1 |-> hdr_data[15:13] == 3'h2)
    else $error("flags");
  a_csum_zero: assert property (hdr_valid && w_q == 4'h6 |-> hdr_data[15:0] == 16'h0000)
    else $error("checksum");
  a_cw_resv: assert property (hdr_valid && w_q == 4'h7 |-> hdr_data[31:28] == 4'h0 && hdr_data[23:16] == 8'h00)
    else $error("reserved");
  a_fail_code: assert property (hdr_valid && w_q == 4'h7 && hdr_data[27] |-> hdr_data[25:24] == 2'h0)
    else $error("code");
  a_rtp_fixed: assert property (hdr_valid && w_q == 4'h8 |-> hdr_data[31:23] == 9'h100)
    else $error("rtp fixed");
  a_rtp_seq: assert property (hdr_valid && w_q == 4'h8 |-> hdr_data[15:0] == seq_q)
    else $error("rtp seq");
endmodule
bind pwf_framer pwf_chk pwf_chk_i (.*);

// File: pwf_sink.sv
// Packet link sink facing the framer's header stream.
// Assumes the framer holds each word until ready is seen.
module pwf_sink (
  input wire logic core_clk, // Clock
  input wire logic rst,      // Reset
  input wire logic slow,     // Stall often
  output logic     hdr_ready // Take word
);
  int seed = 7;
  always @(posedge core_clk) hdr_ready <= !rst && (!slow || ($random(seed) & 3) == 0);
endmodule

// File: testbench.sv
// Self-checking bench of the header framer.
// Assumes the framer, its package and the sink model.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0;
  logic s_axi_rready = 1, tx_req_valid = 0, rx_valid = 0, rx_last = 0, slow = 0, aw = 1, rtp = 1;
  logic signal_loss_defect = 0, frame_alignment_loss = 0, alarm_indication_defect = 0, packet_loss_state = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rx_data = 0, s_axi_rdata, hdr_data, rtp_timestamp, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_req_ready, hdr_valid;
  logic hdr_last, hdr_ready, rx_ready, rx_accept, rx_drop, xr4_due, xr5_due;
  pwf_pkg::pwf_txreq_t tx_req = '0;
  pwf_pkg::pwf_rxinfo_t rx_info;
  logic [31:0] wq[$];
  logic [15:0] sq[2] = '{16'h0, 16'h0};
  int err_total = 0, cmp_count = 0, cyc = 0, seed = 13613, n4 = 0, n5 = 0;
  pwf_framer #(.TS_TICK_CYC(4), .XR_PERIOD_CYC(20)) pwf_framer_i (.*);
  pwf_sink pwf_sink_i (.*);
  initial forever #2.5 core_clk = !core_clk;
  always @(posedge core_clk) if (hdr_valid && hdr_ready) wq.push_back(hdr_data);
  always @(posedge core_clk) if (++cyc == 20000) begin
    err_total++;
    results();
  end
  ////////////////////////////////////////////////////////////////
  task chk(input logic [35:0] g, input logic [35:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, r);
  endtask
  task rd(input logic [7:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
  endtask
  task tx(input logic s, input logic ra, input logic [15:0] n);
    logic l;
    logic [1:0] m;
    logic [15:0] h;
    h = rtp ? 16'd12 : 16'd0;
    l = aw ? (signal_loss_defect | frame_alignment_loss | alarm_indication_defect) : signal_loss_defect;
    m = l ? 2'h0 : s ? 2'h3 : ra && aw ? 2'h2 : 2'h0;
    tx_req <= '{s, ra, n}; tx_req_valid <= 1;
    do @(posedge core_clk); while (!tx_req_ready);
    tx_req_valid <= 0; wq.delete();
    do @(posedge core_clk); while (!(hdr_valid && hdr_ready && hdr_last));
    #1;
    chk(wq.size(), rtp ? 11 : 8);
    chk(wq[0], {16'h4500, n + 16'd32 + h});
    chk(wq[5], 32'hC123D456);
    chk(wq[6], {n + 16'd12 + h, 16'h0});
    chk(wq[7], {4'h0, l, packet_loss_state, m, 8'h0, sq[s]});
    if (rtp) chk(wq[8], {9'h100, s ? 7'h4F : 7'h06, sq[s]});
    sq[s]++;
  endtask
  task rxd(input logic [7:0] t);
    for (int i = 0; i < 11; i++) begin
      rx_data <= i == 0 ? 32'h45000040 : i == 2 ? {t, 24'h110000} : i == 5 ? 32'hD456C123 :
                 i == 7 ? 32'h03000ABC : $random(seed);
      rx_valid <= 1; rx_last <= i == 10;
      @(posedge core_clk);
    end
    rx_valid <= 0; rx_last <= 0;
    @(posedge core_clk);
    chk({rx_ready, rx_accept, rx_drop}, t != 0 ? 6 : 5);
    if (t != 0) chk(rx_info, {4'h3, 16'h0ABC, 16'hD456});
  endtask
  task results;
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    rd(8'h04); chk(d, 32'hC000C000);
    wr(8'h04, 32'hD4560123, 2);
    wr(8'h04, 32'h03FFC123, 2);
    wr(8'h20, 0, 2);
    wr(8'h00, 2, 2);
    rd(8'h18); chk(d[2], 1);
    wr(8'h18, 32'h4, 0); rd(8'h18); chk(d, 0);
    wr(8'h04, 32'hD456C123, 0); wr(8'h10, 32'h4F06, 0); wr(8'h00, 32'h2D, 0);
    d = rtp_timestamp;
    repeat (40) begin
      @(posedge core_clk); n4 += xr4_due; n5 += xr5_due;
    end
    chk(n4, 2);
    chk(n5, 0);
    chk(rtp_timestamp, d + 32'd10);
    for (int k = 0; k < 24; k++) begin
      if (k == 12) begin
        wr(8'h00, 32'h5, 0); aw = 0; slow <= 1;
      end
      if (k == 18) begin
        wr(8'h00, 32'h1, 0); rtp = 0;
      end
      {signal_loss_defect, frame_alignment_loss, alarm_indication_defect, packet_loss_state} <= 4'($random(seed));
      repeat (3) @(posedge core_clk);
      tx(1'($random(seed)), 1'($random(seed)), 16'd20 + 16'($random(seed) & 255));
    end
    rxd(8'h00);
    rxd(8'h40);
    rd(8'h1C); chk(d, 1);
    rd(8'h20); chk({s_axi_rresp, d}, 34'h200000000);
    results();
  end
endmodule
